// *** rtl/uart_flow_control_cfg.svh ***
// constants for the per-channel flow-control block: offsets, fields, resets, codes
// assumes a 32-bit apb register window with one register per aligned word
`ifndef UART_FLOW_CONTROL_CFG_SVH
`define UART_FLOW_CONTROL_CFG_SVH

// register byte offsets
`define UFC_OFF_FEATURE     8'h00
`define UFC_OFF_FIFOCTRL    8'h04
`define UFC_OFF_FIFOEXT     8'h08
`define UFC_OFF_INTEN       8'h0c
`define UFC_OFF_UPPER       8'h10
`define UFC_OFF_LOWER       8'h14
`define UFC_OFF_MODEMCTRL   8'h18
`define UFC_OFF_RESUME1     8'h1c
`define UFC_OFF_RESUME2     8'h20
`define UFC_OFF_STOP1       8'h24
`define UFC_OFF_STOP2       8'h28
`define UFC_OFF_FLOWSTAT    8'h2c
`define UFC_OFF_INTSRC      8'h30
`define UFC_OFF_MODEMSTAT   8'h34
`define UFC_OFF_FILL        8'h38

// field positions
`define UFC_FEAT_AUTO_CTS   7
`define UFC_FEAT_AUTO_RTS   6
`define UFC_IEN_CTS         7
`define UFC_IEN_RTS         6
`define UFC_IEN_XOFF        5
`define UFC_FS_RTS          5
`define UFC_FS_TXOFF        4
`define UFC_FS_CTS          1
`define UFC_FS_RXOFF        0
`define UFC_MS_CTS          4

// reset values
`define UFC_RST_BYTE        8'h00
`define UFC_RST_UPPER       9'h03c
`define UFC_RST_LOWER       9'h000
`define UFC_RST_CHAR_ON     8'h11
`define UFC_RST_CHAR_OFF    8'h13

// 64-byte mode threshold table
`define UFC_UP_0            9'h008
`define UFC_UP_1            9'h010
`define UFC_UP_2            9'h038
`define UFC_UP_3            9'h03c
`define UFC_LO_0            9'h000
`define UFC_LO_1            9'h008
`define UFC_LO_2            9'h010
`define UFC_LO_3            9'h038

// interrupt source codes
`define UFC_SRC_NONE        6'h01
`define UFC_SRC_XOFF        6'h10
`define UFC_SRC_RTSCTS      6'h20

`endif

// *** rtl/uart_flow_control_pkg.sv ***
// types shared by the flow-control block
// assumes the constants header is included by the design file
package uart_flow_control_pkg;

  // control character sender states
  typedef enum logic [1:0] {
    SEND_IDLE,
    SEND_FIRST,
    SEND_SECOND
  } send_state_type;

endpackage

// *** rtl/uart_flow_control.sv ***
// per-channel uart flow control: auto rts/cts and xon/xoff characters
// assumes the uart datapath gives fill count, stop-bit and received-char pulses
// on this clock, and takes a tx permit plus a control-character request
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "uart_flow_control_cfg.svh"

module uart_flow_control #(
  parameter int CNT_W = 9                 // fill count width, 0..256
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // receive datapath
  input  wire logic [CNT_W-1:0] rxFillCount,
  input  wire logic             rxStopBit,
  input  wire logic             rxCharValid,
  input  wire logic [7:0]       rxChar,
  // transmit datapath
  output logic                  txAllow,
  output logic                  txCtrlReq,
  output logic      [7:0]       txCtrlChar,
  input  wire logic             txCtrlAck,
  // pins and interrupt
  output logic                  requestToSendOutN,
  input  wire logic             clearToSendInN,
  output logic                  flowIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0]       featureCtrl_ff;        // feature_control_bits
  logic [7:0]       fifoCtrl_ff;           // fifo_control_bits
  logic [7:0]       fifoExt_ff;            // fifo_extension_bits
  logic [7:0]       intEnable_ff;          // interrupt_enable_bits
  logic [CNT_W-1:0] upperReg_ff;           // rx_upper_threshold in 256-mode
  logic [CNT_W-1:0] lowerReg_ff;           // rx_lower_threshold in 256-mode
  logic [7:0]       modemCtrl_ff;          // modem_control_bits, stored only
  logic [7:0]       resumeFirst_ff;        // resume_char_first
  logic [7:0]       resumeSecond_ff;       // resume_char_second
  logic [7:0]       stopFirst_ff;          // stop_char_first
  logic [7:0]       stopSecond_ff;         // stop_char_second
  logic [31:0]      prdata_ff;             // read data latched in setup phase

  // flow state
  logic             rtsHigh_ff;            // throttle asserted toward remote
  logic             ctsMeta_ff;            // synchroniser stage one
  logic             ctsSync_ff;            // synchronised cts level
  logic             ctsPrev_ff;            // for rising edge detect
  logic             rtsPend_ff;            // pending rts interrupt
  logic             ctsPend_ff;            // pending cts interrupt
  logic             xoffPend_ff;           // pending received-stop interrupt
  logic             txOff_ff;              // we sent a stop char
  logic             rxOff_ff;              // remote sent a stop char
  logic             sendStop_ff;           // kind of char being sent
  uart_flow_control_pkg::send_state_type sendState_ff;
  uart_flow_control_pkg::send_state_type nxt_sendState;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire       setupPhase = psel & ~penable;
  wire       accessDone = psel & penable;  // zero wait: pready always high
  wire       wrDone     = accessDone & pwrite;
  wire       addrHit    = (paddr <= `UFC_OFF_FILL) && (paddr[1:0] == 2'b00);
  wire       wrFeature  = wrDone & (paddr == `UFC_OFF_FEATURE);
  wire       wrFifoCtrl = wrDone & (paddr == `UFC_OFF_FIFOCTRL);
  wire       wrFifoExt  = wrDone & (paddr == `UFC_OFF_FIFOEXT);
  wire       wrIntEn    = wrDone & (paddr == `UFC_OFF_INTEN);
  wire       wrUpper    = wrDone & (paddr == `UFC_OFF_UPPER);
  wire       wrLower    = wrDone & (paddr == `UFC_OFF_LOWER);
  wire       wrModem    = wrDone & (paddr == `UFC_OFF_MODEMCTRL);
  wire       wrRes1     = wrDone & (paddr == `UFC_OFF_RESUME1);
  wire       wrRes2     = wrDone & (paddr == `UFC_OFF_RESUME2);
  wire       wrStop1    = wrDone & (paddr == `UFC_OFF_STOP1);
  wire       wrStop2    = wrDone & (paddr == `UFC_OFF_STOP2);
  // read side effects happen once, at the completing edge
  wire       rdModemStat = accessDone & ~pwrite & (paddr == `UFC_OFF_MODEMSTAT);
  wire       rdIntSrc    = accessDone & ~pwrite & (paddr == `UFC_OFF_INTSRC);

  // zero wait states: every register answers from flops or a short mux
  assign pready  = 1'b1;
  assign pslverr = accessDone & ~addrHit;
  assign prdata  = prdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode
  wire       autoRts   = featureCtrl_ff[`UFC_FEAT_AUTO_RTS];
  wire       autoCts   = featureCtrl_ff[`UFC_FEAT_AUTO_CTS];
  wire [1:0] txSel     = featureCtrl_ff[3:2];
  wire [1:0] rxSel     = featureCtrl_ff[1:0];
  wire       mode256   = fifoCtrl_ff[0] & fifoExt_ff[0];

  // 64-byte table lookups; software thresholds only in 256-mode
  wire [CNT_W-1:0] upTable = (fifoCtrl_ff[7:6] == 2'b00) ? `UFC_UP_0 :
                             (fifoCtrl_ff[7:6] == 2'b01) ? `UFC_UP_1 :
                             (fifoCtrl_ff[7:6] == 2'b10) ? `UFC_UP_2 : `UFC_UP_3;
  wire [CNT_W-1:0] loTable = (fifoCtrl_ff[5:4] == 2'b00) ? `UFC_LO_0 :
                             (fifoCtrl_ff[5:4] == 2'b01) ? `UFC_LO_1 :
                             (fifoCtrl_ff[5:4] == 2'b10) ? `UFC_LO_2 : `UFC_LO_3;
  // no check of upper > lower: software owns that ordering
  wire [CNT_W-1:0] upperThr = mode256 ? upperReg_ff : upTable;
  wire [CNT_W-1:0] lowerThr = mode256 ? lowerReg_ff : loTable;
  wire       overUpper = rxFillCount > upperThr;
  wire       atLower   = rxFillCount == lowerThr;

  ////////////////////////////////////////////////////////////////////////////
  // receive character matching; equal on and off characters count as resume
  wire stopMatch   = (rxSel[1] & (rxChar == stopFirst_ff)) |
                     (rxSel[0] & (rxChar == stopSecond_ff));
  wire resumeMatch = (rxSel[1] & (rxChar == resumeFirst_ff)) |
                     (rxSel[0] & (rxChar == resumeSecond_ff));
  wire gotStop     = rxCharValid & stopMatch & ~resumeMatch;
  wire gotResume   = rxCharValid & resumeMatch;

  // events feeding the interrupt flags
  wire rtsRise  = autoRts & ~rtsHigh_ff & overUpper & rxStopBit;
  wire ctsRise  = autoCts & ctsSync_ff & ~ctsPrev_ff;
  wire rtsEvent = rtsRise & intEnable_ff[`UFC_IEN_RTS];
  wire ctsEvent = ctsRise & intEnable_ff[`UFC_IEN_CTS];
  wire xoffEvent = gotStop & intEnable_ff[`UFC_IEN_XOFF];

  ////////////////////////////////////////////////////////////////////////////
  // outputs toward pins and datapath
  assign requestToSendOutN = rtsHigh_ff;
  // gating only stops the next character; the shifter finishes its current one
  assign txAllow  = ~(autoCts & ctsSync_ff) & ~rxOff_ff;
  assign flowIrq  = rtsPend_ff | ctsPend_ff | xoffPend_ff;
  assign txCtrlReq = sendState_ff != uart_flow_control_pkg::SEND_IDLE;
  assign txCtrlChar =
    (sendState_ff == uart_flow_control_pkg::SEND_FIRST) ?
      (sendStop_ff ? stopFirst_ff : resumeFirst_ff) :
      (sendStop_ff ? stopSecond_ff : resumeSecond_ff);

  // status views
  wire [7:0] flowStatus = {2'b00, autoRts & rtsHigh_ff, txOff_ff,
                           2'b00, autoCts & ctsSync_ff, rxOff_ff};
  wire [5:0] intSource  = (rtsPend_ff | ctsPend_ff) ? `UFC_SRC_RTSCTS :
                          xoffPend_ff ? `UFC_SRC_XOFF : `UFC_SRC_NONE;
  wire [7:0] modemStatus = {3'b000, ~ctsSync_ff, 4'h0};

  // read mux, sampled in the setup phase
  wire [7:0] rdByte =
    (paddr == `UFC_OFF_FEATURE)   ? featureCtrl_ff  :
    (paddr == `UFC_OFF_FIFOCTRL)  ? fifoCtrl_ff     :
    (paddr == `UFC_OFF_FIFOEXT)   ? fifoExt_ff      :
    (paddr == `UFC_OFF_INTEN)     ? intEnable_ff    :
    (paddr == `UFC_OFF_MODEMCTRL) ? modemCtrl_ff    :
    (paddr == `UFC_OFF_RESUME1)   ? resumeFirst_ff  :
    (paddr == `UFC_OFF_RESUME2)   ? resumeSecond_ff :
    (paddr == `UFC_OFF_STOP1)     ? stopFirst_ff    :
    (paddr == `UFC_OFF_STOP2)     ? stopSecond_ff   :
    (paddr == `UFC_OFF_FLOWSTAT)  ? flowStatus      :
    (paddr == `UFC_OFF_INTSRC)    ? {2'b00, intSource} :
    (paddr == `UFC_OFF_MODEMSTAT) ? modemStatus     : `UFC_RST_BYTE;
  wire [CNT_W-1:0] rdCount =
    (paddr == `UFC_OFF_UPPER) ? upperThr :
    (paddr == `UFC_OFF_LOWER) ? lowerThr :
    (paddr == `UFC_OFF_FILL)  ? rxFillCount : '0;
  wire [31:0] rdWord = {{(32-CNT_W){1'b0}}, rdCount} | {24'h000000, rdByte};

  ////////////////////////////////////////////////////////////////////////////
  // control byte registers; thresholds take writes only in 256-mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      featureCtrl_ff  <= `UFC_RST_BYTE;
      fifoCtrl_ff     <= `UFC_RST_BYTE;
      fifoExt_ff      <= `UFC_RST_BYTE;
      intEnable_ff    <= `UFC_RST_BYTE;
      modemCtrl_ff    <= `UFC_RST_BYTE;
    end else begin
      if (wrFeature)  featureCtrl_ff <= pwdata[7:0];
      if (wrFifoCtrl) fifoCtrl_ff    <= pwdata[7:0];
      if (wrFifoExt)  fifoExt_ff     <= pwdata[7:0];
      if (wrIntEn)    intEnable_ff   <= pwdata[7:0];
      if (wrModem)    modemCtrl_ff   <= pwdata[7:0];
    end
  end

  // thresholds and flow characters
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      upperReg_ff     <= `UFC_RST_UPPER;
      lowerReg_ff     <= `UFC_RST_LOWER;
      resumeFirst_ff  <= `UFC_RST_CHAR_ON;
      resumeSecond_ff <= `UFC_RST_CHAR_ON;
      stopFirst_ff    <= `UFC_RST_CHAR_OFF;
      stopSecond_ff   <= `UFC_RST_CHAR_OFF;
    end else begin
      if (wrUpper & mode256) upperReg_ff <= pwdata[CNT_W-1:0];
      if (wrLower & mode256) lowerReg_ff <= pwdata[CNT_W-1:0];
      if (wrRes1)  resumeFirst_ff  <= pwdata[7:0];
      if (wrRes2)  resumeSecond_ff <= pwdata[7:0];
      if (wrStop1) stopFirst_ff    <= pwdata[7:0];
      if (wrStop2) stopSecond_ff   <= pwdata[7:0];
    end
  end

  // read data capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) prdata_ff <= 32'h00000000;
    else if (setupPhase & ~pwrite) prdata_ff <= rdWord;
  end

  ////////////////////////////////////////////////////////////////////////////
  // cts synchroniser; stage one is read only by stage two
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctsMeta_ff <= 1'b0;
      ctsSync_ff <= 1'b0;
      ctsPrev_ff <= 1'b0;
    end else begin
      ctsMeta_ff <= clearToSendInN;
      ctsSync_ff <= ctsMeta_ff;
      ctsPrev_ff <= ctsSync_ff;
    end
  end

  // rts hysteresis: set on stop bit above upper, clear when fill meets lower
  always_ff @(posedge clock or posedge rst) begin
    if (rst) rtsHigh_ff <= 1'b0;
    else if (!autoRts) rtsHigh_ff <= 1'b0;
    else if (rtsRise) rtsHigh_ff <= 1'b1;
    else if (rtsHigh_ff && atLower) rtsHigh_ff <= 1'b0;
  end

  // interrupt flags; a new event beats the clearing read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rtsPend_ff  <= 1'b0;
      ctsPend_ff  <= 1'b0;
      xoffPend_ff <= 1'b0;
    end else begin
      rtsPend_ff  <= rtsEvent | (rtsPend_ff & ~rdModemStat);
      ctsPend_ff  <= ctsEvent | (ctsPend_ff & ~rdModemStat);
      xoffPend_ff <= xoffEvent | (xoffPend_ff & ~rdIntSrc & ~gotResume);
    end
  end

  // remote stop/resume state from received characters
  // clearing the selection releases tx, so a lost resume cannot stall it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) rxOff_ff <= 1'b0;
    else if (rxSel == 2'b00) rxOff_ff <= 1'b0;
    else if (gotResume) rxOff_ff <= 1'b0;
    else if (gotStop) rxOff_ff <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control character sender
  wire startStop   = (txSel != 2'b00) & ~txOff_ff & overUpper;
  wire startResume = (txSel != 2'b00) & txOff_ff & (rxFillCount <= lowerThr);
  wire idle        = sendState_ff == uart_flow_control_pkg::SEND_IDLE;

  always_comb begin
    nxt_sendState = sendState_ff;
    case (sendState_ff)
      uart_flow_control_pkg::SEND_IDLE: begin
        if (startStop | startResume) begin
          nxt_sendState = txSel[1] ? uart_flow_control_pkg::SEND_FIRST
                                   : uart_flow_control_pkg::SEND_SECOND;
        end
      end
      uart_flow_control_pkg::SEND_FIRST: begin
        if (txCtrlAck) begin
          nxt_sendState = txSel[0] ? uart_flow_control_pkg::SEND_SECOND
                                   : uart_flow_control_pkg::SEND_IDLE;
        end
      end
      uart_flow_control_pkg::SEND_SECOND: begin
        if (txCtrlAck) nxt_sendState = uart_flow_control_pkg::SEND_IDLE;
      end
      default: nxt_sendState = uart_flow_control_pkg::SEND_IDLE;
    endcase
  end

  // sender registers; the tx and rx selections never touch each other
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sendState_ff <= uart_flow_control_pkg::SEND_IDLE;
      txOff_ff     <= 1'b0;
      sendStop_ff  <= 1'b0;
    end else begin
      sendState_ff <= nxt_sendState;
      if (txSel == 2'b00) txOff_ff <= 1'b0;
      else if (idle && startStop) begin
        txOff_ff    <= 1'b1;
        sendStop_ff <= 1'b1;
      end else if (idle && startResume) begin
        txOff_ff    <= 1'b0;
        sendStop_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence rtsRaise_s;
    autoRts && !rtsHigh_ff && overUpper && rxStopBit;
  endsequence

  rts_rise_a: assert property ($rose(rtsHigh_ff) |-> $past(rtsRise))
    else $error("rts rose without stop bit above upper");
  rts_set_a: assert property (rtsRaise_s |=> requestToSendOutN)
    else $error("rts did not rise above upper");
  rts_hold_a: assert property (autoRts && rtsHigh_ff && !atLower ##1 autoRts
                               |-> requestToSendOutN)
    else $error("rts dropped before reaching lower");
  rts_drop_a: assert property (autoRts && rtsHigh_ff && atLower
                               |=> !requestToSendOutN)
    else $error("rts stayed high at lower");
  rts_off_a: assert property (!autoRts |=> !requestToSendOutN)
    else $error("rts high while throttling off");
  up_decode_a: assert property (!mode256 && fifoCtrl_ff[7:6] == 2'b10
                                |-> upperThr == 9'h038)
    else $error("upper table wrong");
  lo_decode_a: assert property (!mode256 && fifoCtrl_ff[5:4] == 2'b11
                                |-> lowerThr == 9'h038)
    else $error("lower table wrong");
  cts_gate_a: assert property (autoCts && ctsSync_ff |-> !txAllow)
    else $error("tx allowed while cts high");
  cts_irq_a: assert property (ctsEvent |=> flowIrq && intSource == 6'h20)
    else $error("cts rise did not interrupt");
  irq_clear_a: assert property (rdModemStat && !rtsEvent && !ctsEvent
                                |=> !rtsPend_ff && !ctsPend_ff)
    else $error("modem status read did not clear");
  xoff_send_a: assert property (idle && startStop
                                |=> txCtrlReq && txOff_ff && sendStop_ff)
    else $error("stop character not requested");
  rx_stop_a: assert property (rxSel != 2'b00 && gotStop |=> rxOff_ff ##0 !txAllow)
    else $error("received stop did not suspend");

endmodule

// *** test/far_uart_model.sv ***
// far-side model: remote uart sender feeding the rx fifo count, plus the tx shifter
// assumes the bench pulses sendGo or drainGo for one clock, set after a rising edge
`timescale 1ns/1ps

module far_uart_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // bench control
  input  wire logic       sendGo,            // remote starts one character
  input  wire logic [7:0] sendData,          // that character
  input  wire logic       drainGo,           // cpu pops one byte
  // block side
  input  wire logic       requestToSendOutN,
  output logic      [8:0] rxFillCount,
  output logic            rxStopBit,
  output logic            rxCharValid,
  output logic      [7:0] rxChar,
  input  wire logic       txCtrlReq,
  output logic            txCtrlAck
);
  logic [1:0] ackWait;                       // slow shifter, waits before taking a char
  logic       sendOk;                        // remote may start a character

  assign sendOk = sendGo & ~requestToSendOutN;

  ////////////////////////////////////////////////////////////////////////////////
  // receive side: one character lands per accepted start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxFillCount <= 9'h000;
      rxStopBit   <= 1'b0;
      rxCharValid <= 1'b0;
      rxChar      <= 8'h00;
    end else begin
      rxStopBit   <= sendOk;
      rxCharValid <= sendOk;
      // idle data toggles so a stale byte can never match
      rxChar      <= sendOk ? sendData : ~rxChar;
      if (sendOk) begin
        rxFillCount <= rxFillCount + 9'h001;
      end else if (drainGo && rxFillCount != 9'h000) begin
        rxFillCount <= rxFillCount - 9'h001;
      end
    end
  end

  // tx shifter: takes a control char after a few cycles, one pulse per char
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ackWait   <= 2'h0;
      txCtrlAck <= 1'b0;
    end else begin
      txCtrlAck <= txCtrlReq && ackWait == 2'h3 && !txCtrlAck;
      ackWait   <= (txCtrlReq && !txCtrlAck) ? ackWait + 2'h1 : 2'h0;
    end
  end
endmodule

// *** test/tb_top.sv ***
// bench for the flow-control block: apb master tasks and directed sequences
// assumes the far-side model stands in for the uart datapath and remote sender
`timescale 1ns/1ps
`include "uart_flow_control_cfg.svh"

module tb_top;
  // clock, reset, apb
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // datapath and pins
  logic [8:0]  fill;
  logic        stopBit, charValid, txAllow, txCtrlReq, txCtrlAck, rtsN, flowIrq;
  logic [7:0]  rxCh, txCtrlChar;
  logic        ctsN = 1'b0;
  logic        sendGo = 1'b0;
  logic        drainGo = 1'b0;
  logic [7:0]  sendData = 8'h00;
  // bookkeeping
  int          mismatches = 0;
  int          nCompared = 0;
  logic [31:0] upTab [4] = '{32'h8, 32'h10, 32'h38, 32'h3c};
  logic [31:0] loTab [4] = '{32'h0, 32'h8, 32'h10, 32'h38};
  logic [31:0] r;
  logic        e;

  uart_flow_control DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxFillCount(fill), .rxStopBit(stopBit), .rxCharValid(charValid),
    .rxChar(rxCh), .txAllow(txAllow), .txCtrlReq(txCtrlReq), .txCtrlChar(txCtrlChar),
    .txCtrlAck(txCtrlAck), .requestToSendOutN(rtsN), .clearToSendInN(ctsN),
    .flowIrq(flowIrq));

  far_uart_model far (.clock(clock), .rst(rst), .sendGo(sendGo), .sendData(sendData),
    .drainGo(drainGo), .requestToSendOutN(rtsN), .rxFillCount(fill), .rxStopBit(stopBit),
    .rxCharValid(charValid), .rxChar(rxCh), .txCtrlReq(txCtrlReq), .txCtrlAck(txCtrlAck));

  initial begin
    forever #2.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high, then one idle
  // edge so that side effects of the completing edge are visible to the caller
  task automatic apb(input logic isWr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= isWr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  // remote sends one char / cpu pops bytes; both leave time for the flags to settle
  task automatic send(input logic [7:0] ch);
    @(posedge clock);
    sendGo <= 1'b1;
    sendData <= ch;
    @(posedge clock);
    sendGo <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic drain(input int n);
    repeat (n) begin
      @(posedge clock);
      drainGo <= 1'b1;
      @(posedge clock);
      drainGo <= 1'b0;
    end
    repeat (3) @(posedge clock);
  endtask

  // waits for the shifter to take a control char and checks which one it was
  task automatic ctrl(input logic [7:0] ch);
    do begin
      @(negedge clock);
    end while (txCtrlAck !== 1'b1);
    chk({24'h0, txCtrlChar}, {24'h0, ch});
    @(posedge clock);
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, well beyond the length of the sequence below
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(`UFC_OFF_RESUME1, 32'h11);
    rd(`UFC_OFF_STOP2, 32'h13);
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, e}, 32'h1);
    // nothing enabled: filling past upper leaves pin and requests alone
    repeat (10) send(8'h41);
    chk({30'h0, rtsN, txCtrlReq}, 32'h0);
    drain(10);
    for (int c = 0; c < 4; c++) begin
      wr(`UFC_OFF_FIFOCTRL, {24'h0, c[1:0], c[1:0], 4'h1});
      wr(`UFC_OFF_UPPER, 32'h20);
      rd(`UFC_OFF_UPPER, upTab[c]);
      rd(`UFC_OFF_LOWER, loTab[c]);
    end
    // 256-byte mode: software thresholds, upper kept above lower
    wr(`UFC_OFF_FIFOEXT, 32'h1);
    wr(`UFC_OFF_UPPER, 32'h5);
    wr(`UFC_OFF_LOWER, 32'h2);
    rd(`UFC_OFF_UPPER, 32'h5);
    // modem control is stored and read back; it gates nothing here
    wr(`UFC_OFF_MODEMCTRL, 32'h64);
    rd(`UFC_OFF_MODEMCTRL, 32'h64);
    wr(`UFC_OFF_INTEN, 32'h40);
    wr(`UFC_OFF_FEATURE, 32'h40);
    chk({31'h0, rtsN}, 32'h0);
    repeat (5) send(8'h41);
    chk({31'h0, rtsN}, 32'h0);
    send(8'h41);
    chk({30'h0, rtsN, flowIrq}, 32'h3);
    rd(`UFC_OFF_FLOWSTAT, 32'h20);
    rd(`UFC_OFF_INTSRC, 32'h20);
    rd(`UFC_OFF_MODEMSTAT, 32'h10);
    chk({31'h0, flowIrq}, 32'h0);
    send(8'h42);
    rd(`UFC_OFF_FILL, 32'h6);
    drain(3);
    chk({31'h0, rtsN}, 32'h1);
    drain(1);
    chk({31'h0, rtsN}, 32'h0);
    drain(2);
    // cts pin high holds the transmitter and flags it
    wr(`UFC_OFF_INTEN, 32'h80);
    wr(`UFC_OFF_FEATURE, 32'h80);
    @(posedge clock) ctsN <= 1'b1;
    repeat (6) @(posedge clock);
    chk({30'h0, txAllow, flowIrq}, 32'h1);
    rd(`UFC_OFF_FLOWSTAT, 32'h02);
    rd(`UFC_OFF_MODEMSTAT, 32'h0);
    chk({31'h0, flowIrq}, 32'h0);
    @(posedge clock) ctsN <= 1'b0;
    repeat (6) @(posedge clock);
    chk({31'h0, txAllow}, 32'h1);
    // every transmit selection: stop chars going up, resume chars coming down
    wr(`UFC_OFF_RESUME1, 32'h21);
    wr(`UFC_OFF_RESUME2, 32'h22);
    wr(`UFC_OFF_STOP1, 32'h23);
    wr(`UFC_OFF_STOP2, 32'h24);
    for (int s = 1; s < 4; s++) begin
      wr(`UFC_OFF_FEATURE, {28'h0, s[1:0], 2'h0});
      repeat (6) send(8'h41);
      if (s[1]) ctrl(8'h23);
      if (s[0]) ctrl(8'h24);
      rd(`UFC_OFF_FLOWSTAT, 32'h10);
      drain(4);
      if (s[1]) ctrl(8'h21);
      if (s[0]) ctrl(8'h22);
      drain(2);
    end
    // every receive selection: matching stop pauses, matching resume restarts
    wr(`UFC_OFF_INTEN, 32'h20);
    for (int s = 1; s < 4; s++) begin
      wr(`UFC_OFF_FEATURE, {30'h0, s[1:0]});
      send(s[1] ? 8'h23 : 8'h24);
      chk({30'h0, txAllow, flowIrq}, 32'h1);
      rd(`UFC_OFF_INTSRC, 32'h10);
      send(s[1] ? 8'h21 : 8'h22);
      chk({31'h0, txAllow}, 32'h1);
    end
    print_verdict();
  end
endmodule
